// ---- src/skip_branch_or_inc_exec.sv ----
/*
  Execution unit for decrement/increment with skip, increment, the two
  inclusive-OR forms and the unconditional jump. Holds the accumulator,
  zero flag, program counter, high latch and a 128-byte file register
  window, all reached over a classic Wishbone slave.
  Assumes a single 100 MHz clock, synchronous active-high reset, and a
  master that holds each request until it sees ack or err.
*/
// The Wishbone register port and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "exec_map.svh"

// Notes on behaviour
// - Decrement-skip subtracts one, destination bit routes result
// - Zero decrement result replaces next with no-operation
// - Increment-skip adds one, skips on zero result
// - Jump loads 11-bit immediate into PC low
// - Jump fills PC upper from latch bits six:three
// - Jump takes two cycles, flushing next instruction
// - OR-literal ORs accumulator, result to accumulator, zero
// - Increment adds one, routes result, updates zero
// - OR-register ORs accumulator with file, routes, zero
module skip_branch_or_inc_exec
  import exec_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [31:0] adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  output logic             err_o,
  // Core status towards the fetch path
  output logic      [14:0] pc_o,
  output logic             busy_o
);

  core_s  q;        // Registered state
  core_s  n;        // Next state
  exec_if x ();     // Link to the datapath
  sel_e   sel;      // Register addressed by the current request
  logic   req;      // New request, not yet answered
  logic   accept;   // Request taken this cycle, answered in the next
  logic [31:0] cur; // Current value of the addressed register
  logic [31:0] wv;  // Write value merged under byte enables

  // Map a byte address onto a register select
  function automatic sel_e map_addr(input logic [31:0] a);
    sel_e s;
    s = SEL_NONE;
    if (a[31:12] == 20'h0_0000) begin
      if (a[11:0] >= `OFS_FILE_BASE && a[11:0] <= `OFS_FILE_TOP && a[1:0] == 2'h0) begin
        s = SEL_FILE;
      end else begin
        case (a[11:0])
          `OFS_INSTR:  s = SEL_INSTR;
          `OFS_ACC:    s = SEL_ACC;
          `OFS_STATUS: s = SEL_STATUS;
          `OFS_PCH:    s = SEL_PCH;
          `OFS_PC:     s = SEL_PC;
          `OFS_CYCLES: s = SEL_CYCLES;
          default:     s = SEL_NONE;
        endcase
      end
    end
    return s;
  endfunction

  // Merge new write data into an old word lane by lane
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Datapath instance; it sees only the carrier
  op_decode u_dec (
    .x (x)
  );

  // Feed the datapath from the registered state
  assign x.instr = q.instr;
  assign x.acc   = q.acc;
  assign x.pch   = q.pch;
  assign x.fval  = q.fmem[x.faddr];

  // Outputs come straight from flip-flops, except busy_o, which is decoded from the state register
  assign dat_o  = q.rdata;
  assign ack_o  = q.ack;
  assign err_o  = q.err;
  assign pc_o   = q.pc;
  assign busy_o = (q.st != ST_IDLE);

  // Bus request qualification
  always_comb begin
    sel = map_addr(adr_i);
    req = cyc_i & stb_i & ~q.ack & ~q.err;
    // Writes wait while an instruction is in flight so that the
    // bus never races the datapath for the same register
    accept = req & (~we_i | (q.st == ST_IDLE));
  end

  // Current contents of the addressed register, narrow data in low bits
  always_comb begin
    case (sel)
      SEL_INSTR:  cur = {18'h0_0000, q.instr};
      SEL_ACC:    cur = {24'h00_0000, q.acc};
      SEL_STATUS: cur = {28'h000_0000, q.unknown, q.skip_seen,
                         (q.st != ST_IDLE), q.zero};
      SEL_PCH:    cur = {25'h000_0000, q.pch};
      SEL_PC:     cur = {17'h0_0000, q.pc};
      SEL_CYCLES: cur = {16'h0000, q.cycles};
      SEL_FILE:   cur = {24'h00_0000, q.fmem[adr_i[8:2]]};
      default:    cur = 32'h0000_0000;
    endcase
    wv = merge(cur, dat_i, sel_i);
  end

  // Next-state logic: sequencer first, then bus accesses
  always_comb begin
    n     = q;
    n.ack = 1'b0;
    n.err = 1'b0;

    // Instruction cycle sequencer
    case (q.st)
      ST_IDLE: begin
        n.st = ST_IDLE;  // Waits for an issue over the bus
      end
      ST_EXEC: begin
        n.cycles = q.cycles + 16'h0001;
        if (x.to_acc) begin
          n.acc = x.result;
        end
        if (x.to_file) begin
          n.fmem[x.faddr] = x.result;
        end
        // Skip forms leave the zero flag alone
        if (x.upd_zero) begin
          n.zero = (x.result == 8'h00);
        end
        if (x.jump) begin
          n.pc        = x.target;
          n.skip_seen = 1'b0;
          n.st        = ST_FLUSH;
        end else if (x.skip) begin
          n.pc        = q.pc + 15'h0001;
          n.skip_seen = 1'b1;
          n.st        = ST_FLUSH;
        end else begin
          n.pc        = q.pc + 15'h0001;
          n.skip_seen = 1'b0;
          n.st        = ST_IDLE;
        end
      end
      ST_FLUSH: begin
        // Second cycle runs a no-operation in place of the next word
        n.cycles = q.cycles + 16'h0001;
        if (q.skip_seen) begin
          n.pc = q.pc + 15'h0001;
        end
        n.st = ST_IDLE;
      end
      default: begin
        n.st = ST_IDLE;
      end
    endcase

    // Wishbone answer: one cycle of ack or err per request
    if (accept) begin
      if (sel == SEL_NONE) begin
        n.err   = 1'b1;   // Unmapped address, nothing changes
        n.rdata = 32'h0000_0000;
      end else begin
        n.ack   = 1'b1;
        n.rdata = cur;
        if (we_i) begin
          case (sel)
            SEL_INSTR: begin
              // Issue: the word executes in the next cycle
              n.instr   = wv[13:0];
              n.unknown = (decode_op(wv[13:0]) == OP_NOP);
              n.st      = ST_EXEC;
            end
            SEL_ACC: begin
              n.acc = wv[7:0];
            end
            SEL_STATUS: begin
              n.zero = wv[`ST_ZERO_BIT];  // Busy, skip, unknown are read-only
            end
            SEL_PCH: begin
              n.pch = wv[6:0];
            end
            SEL_PC: begin
              n.pc = wv[14:0];
            end
            SEL_CYCLES: begin
              n.cycles = 16'h0000;        // Any write clears the count
            end
            SEL_FILE: begin
              n.fmem[adr_i[8:2]] = wv[7:0];
            end
            default: begin
              n.err = 1'b0;
            end
          endcase
        end
      end
    end
  end

  // State register with synchronous reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q.st        <= ST_IDLE;
      q.instr     <= `RST_INSTR;
      q.acc       <= `RST_ACC;
      q.zero      <= 1'b0;
      q.skip_seen <= 1'b0;
      q.unknown   <= 1'b0;
      q.pch       <= `RST_PCH;
      q.pc        <= `RST_PC;
      q.cycles    <= 16'h0000;
      q.fmem      <= '0;
      q.ack       <= 1'b0;
      q.err       <= 1'b0;
      q.rdata     <= 32'h0000_0000;
    end else begin
      q <= n;
    end
  end

endmodule

`default_nettype wire

// ---- src/exec_map.svh ----
/*
  Address map, field positions, opcode encodings and reset values of the
  six-instruction execution unit, all as text macros.
  Assumes it is included by bare name wherever a number is needed.
*/
`ifndef EXEC_MAP_SVH
`define EXEC_MAP_SVH

// Register byte offsets (one aligned 32-bit word each)
`define OFS_INSTR      12'h000
`define OFS_ACC        12'h004
`define OFS_STATUS     12'h008
`define OFS_PCH        12'h00C
`define OFS_PC         12'h010
`define OFS_CYCLES     12'h014
`define OFS_FILE_BASE  12'h200
`define OFS_FILE_TOP   12'h3FC

// Status register bits
`define ST_ZERO_BIT    0
`define ST_BUSY_BIT    1
`define ST_SKIP_BIT    2
`define ST_UNKN_BIT    3

// Instruction word fields
`define INS_W          14
`define OPC_HI         13
`define OPC_LO         8
`define DEST_BIT       7
`define FADDR_HI       6
`define JTAG_HI        13
`define JTAG_LO        11
`define JADDR_HI       10
`define PCH_HI         6
`define PCH_LO         3

// Opcode encodings
`define OPC_DEC_SKIP   6'h0B
`define OPC_INC_SKIP   6'h0F
`define OPC_INC        6'h0A
`define OPC_OR_REG     6'h04
`define OPC_OR_LIT     6'h38
`define JTAG_JUMP      3'h5

// Reset values
`define RST_ACC        8'h00
`define RST_PCH        7'h00
`define RST_PC         15'h0000
`define RST_INSTR      14'h0000

`endif

// ---- src/exec_pkg.sv ----
/*
  Types shared by the execution unit: operation kinds, sequencer states,
  register selects, the state record, and the opcode decode function.
  Assumes exec_map.svh is on the include path.
*/
`include "exec_map.svh"

package exec_pkg;

  // Operation kinds after decode
  typedef enum logic [2:0] {
    OP_NOP, OP_DEC_SKIP, OP_INC_SKIP, OP_JUMP, OP_OR_LIT, OP_INC, OP_OR_REG
  } op_e;

  // Instruction cycle sequencer
  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_FLUSH} state_e;

  // Register selected by a bus address
  typedef enum logic [2:0] {
    SEL_INSTR, SEL_ACC, SEL_STATUS, SEL_PCH, SEL_PC, SEL_CYCLES, SEL_FILE, SEL_NONE
  } sel_e;

  // Whole state of the execution unit
  typedef struct packed {
    state_e          st;
    logic [13:0]     instr;
    logic [7:0]      acc;
    logic            zero;
    logic            skip_seen;
    logic            unknown;
    logic [6:0]      pch;
    logic [14:0]     pc;
    logic [15:0]     cycles;
    logic [127:0][7:0] fmem;
    logic            ack;
    logic            err;
    logic [31:0]     rdata;
  } core_s;

  // Opcode decode, shared by the datapath and the issue logic
  function automatic op_e decode_op(input logic [13:0] ins);
    op_e op;
    op = OP_NOP;
    if (ins[`JTAG_HI:`JTAG_LO] == `JTAG_JUMP) begin
      op = OP_JUMP;
    end else begin
      case (ins[`OPC_HI:`OPC_LO])
        `OPC_DEC_SKIP: op = OP_DEC_SKIP;
        `OPC_INC_SKIP: op = OP_INC_SKIP;
        `OPC_INC:      op = OP_INC;
        `OPC_OR_REG:   op = OP_OR_REG;
        `OPC_OR_LIT:   op = OP_OR_LIT;
        default:       op = OP_NOP;
      endcase
    end
    return op;
  endfunction

endpackage

// ---- src/exec_if.sv ----
/*
  Carrier between the sequencer and the datapath decoder.
  Assumes both ends sit in the same clock domain.
*/
`timescale 1ns/10ps
`default_nettype none

interface exec_if;
  import exec_pkg::*;
  logic [13:0] instr;      // Instruction being executed
  logic [7:0]  acc;        // Current accumulator
  logic [7:0]  fval;       // Value of addressed file register
  logic [6:0]  pch;        // Program counter high latch
  op_e         op;         // Decoded operation
  logic [6:0]  faddr;      // File register address
  logic [7:0]  result;     // Eight-bit result
  logic        to_acc;     // Result goes to accumulator
  logic        to_file;    // Result goes to file register
  logic        upd_zero;   // Zero flag follows result
  logic        skip;       // Next instruction is discarded
  logic        jump;       // Program counter is reloaded
  logic [14:0] target;     // Reload value for the program counter

  modport sequencer (output instr, acc, fval, pch,
                     input  op, faddr, result, to_acc, to_file, upd_zero, skip, jump, target);
  modport decoder   (input  instr, acc, fval, pch,
                     output op, faddr, result, to_acc, to_file, upd_zero, skip, jump, target);
endinterface

`default_nettype wire

// ---- src/op_decode.sv ----
/*
  Combinational datapath: decodes one instruction word and forms its
  result, destination, skip and branch target.
  Assumes the sequencer supplies the file register value for faddr.
*/
`timescale 1ns/10ps
`default_nettype none
`include "exec_map.svh"

module op_decode
  import exec_pkg::*;
(
  // Link to the sequencer
  exec_if.decoder x
);

  logic dbit;  // Destination bit of file-register forms

  // Decode and compute in one pass
  always_comb begin
    dbit       = x.instr[`DEST_BIT];
    x.op       = decode_op(x.instr);
    x.faddr    = x.instr[`FADDR_HI:0];
    x.result   = 8'h00;
    x.to_acc   = 1'b0;
    x.to_file  = 1'b0;
    x.upd_zero = 1'b0;
    x.skip     = 1'b0;
    x.jump     = 1'b0;
    x.target   = 15'h0000;
    case (x.op)
      OP_DEC_SKIP: begin
        x.result  = x.fval - 8'h01;
        x.to_acc  = ~dbit;
        x.to_file = dbit;
        x.skip    = (x.result == 8'h00);
      end
      OP_INC_SKIP: begin
        x.result  = x.fval + 8'h01;
        x.to_acc  = ~dbit;
        x.to_file = dbit;
        x.skip    = (x.result == 8'h00);
      end
      OP_INC: begin
        x.result   = x.fval + 8'h01;
        x.to_acc   = ~dbit;
        x.to_file  = dbit;
        x.upd_zero = 1'b1;
      end
      OP_OR_REG: begin
        x.result   = x.acc | x.fval;
        x.to_acc   = ~dbit;
        x.to_file  = dbit;
        x.upd_zero = 1'b1;
      end
      OP_OR_LIT: begin
        x.result   = x.acc | x.instr[7:0];
        x.to_acc   = 1'b1;
        x.upd_zero = 1'b1;
      end
      OP_JUMP: begin
        x.jump   = 1'b1;
        // Upper bits come from the wide latch field, not the narrow one
        x.target = {x.pch[`PCH_HI:`PCH_LO], x.instr[`JADDR_HI:0]};
      end
      default: begin
        x.result = 8'h00;  // Unknown word runs as a no-operation
      end
    endcase
  end

endmodule

`default_nettype wire

// ---- tb/skip_branch_or_inc_exec_assertions.sv ----
/*
  Checker for the execution unit, watching only its top-level ports.
  Assumes one clock domain, a master that holds each request until answered.
*/
`timescale 1ns/10ps
`default_nettype none
`include "exec_map.svh"

module skip_branch_or_inc_exec_assertions (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Bus side
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [31:0] adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  input  wire logic [31:0] dat_o,
  input  wire logic        ack_o,
  input  wire logic        err_o,
  // Core status
  input  wire logic [14:0] pc_o,
  input  wire logic        busy_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic [6:0] latch;  // Shadow of the high latch, updated on an answered write
  logic       issue;  // Instruction write taken by the slave
  logic       is_jmp;
  logic       is_skp;
  logic       is_pln;

  // Writes only land on the ack edge, so the shadow follows that edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      latch <= 7'h00;
    end else if (ack_o && we_i && adr_i == {20'h0, `OFS_PCH}) begin
      latch <= dat_i[6:0];
    end
  end

  assign issue  = cyc_i && stb_i && we_i && !busy_o && !ack_o && !err_o && adr_i == 32'h0;
  assign is_jmp = dat_i[13:11] == `JTAG_JUMP;
  assign is_skp = !is_jmp && (dat_i[13:8] == `OPC_DEC_SKIP || dat_i[13:8] == `OPC_INC_SKIP);
  assign is_pln = !is_jmp && (dat_i[13:8] == `OPC_INC || dat_i[13:8] == `OPC_OR_REG
                  || dat_i[13:8] == `OPC_OR_LIT);

  sequence s_exec;
    ack_o && busy_o;
  endsequence
  sequence s_flush;
    busy_o ##1 !busy_o;
  endsequence
  sequence s_one;
    !busy_o && pc_o == $past(pc_o, 2) + 15'h1;
  endsequence

  property p_jump_len;
    issue && is_jmp |=> s_exec ##1 s_flush;
  endproperty
  property p_jump_low;
    issue && is_jmp |-> ##2 pc_o[10:0] == $past(dat_i[10:0], 2);
  endproperty
  property p_jump_high;
    issue && is_jmp |-> ##2 pc_o[14:11] == latch[6:3];
  endproperty
  property p_plain;
    issue && is_pln |=> s_exec ##1 s_one;
  endproperty
  property p_skip;
    issue && is_skp |=> s_exec ##1
      (s_one or (busy_o ##1 (!busy_o && pc_o == $past(pc_o, 3) + 15'h2)));
  endproperty
  property p_ack_pulse;
    ack_o |=> !ack_o;
  endproperty
  property p_err_data;
    err_o |-> dat_o == 32'h0 && !ack_o;
  endproperty
  property p_unmapped;
    cyc_i && stb_i && !we_i && !ack_o && !err_o && adr_i[31:12] != 20'h0 |=> err_o;
  endproperty
  property p_reset;
    $fell(rst_i) |-> !busy_o && pc_o == 15'h0;
  endproperty

  a_jump_len:  assert property (p_jump_len) else $error("jump length wrong");
  a_jump_low:  assert property (p_jump_low) else $error("jump low target wrong");
  a_jump_high: assert property (p_jump_high) else $error("jump high bits wrong");
  a_plain:     assert property (p_plain) else $error("plain op not one cycle");
  a_skip:      assert property (p_skip) else $error("skip timing wrong");
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than a cycle");
  a_err_data:  assert property (p_err_data) else $error("error reply carries data");
  a_unmapped:  assert property (p_unmapped) else $error("unmapped read not refused");
  a_reset:     assert property (p_reset) else $error("state not cleared by reset");
endmodule

bind skip_branch_or_inc_exec skip_branch_or_inc_exec_assertions i_chk (.clk_i(clk_i),
  .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
  .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o), .pc_o(pc_o), .busy_o(busy_o));

`default_nettype wire

// ---- tb/wb_host.sv ----
/*
  Software side of the register bus: a classic single-cycle bus master.
  Assumes the caller enters xfer just after a rising clock edge.
*/
`timescale 1ns/10ps
`default_nettype none

module wb_host (
  // Clock
  input  wire logic        clk_i,
  // Request
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic      [31:0] adr_o,
  output logic      [3:0]  sel_o,
  output logic      [31:0] dat_o,
  // Answer
  input  wire logic        ack_i,
  input  wire logic        err_i
);
  // Idle bus at time zero
  initial begin
    {cyc_o, stb_o, we_o, sel_o} = 7'h0;
    adr_o = 32'h0;
    dat_o = 32'h0;
  end

  // Hold everything until ack or err, then scramble the released lines
  task automatic xfer(input logic w, input logic [31:0] a, d, input int gap);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o  <= w;
    adr_o <= a;
    sel_o <= 4'hF;
    dat_o <= d;
    do @(posedge clk_i); while (!(ack_i || err_i));
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    we_o  <= 1'b0;
    adr_o <= ~a;
    dat_o <= ~d;
    repeat (gap + 1) @(posedge clk_i);  // At least one idle cycle between requests
  endtask
endmodule

`default_nettype wire

// ---- tb/skip_branch_or_inc_exec_tb.sv ----
/*
  Self-checking bench: random operands run through all six operations.
  Assumes exec_map.svh on the include path and the bus host model beside it.
*/
`timescale 1ns/10ps
`default_nettype none
`include "exec_map.svh"

module skip_branch_or_inc_exec_tb;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc, stb, we, ack, err, busy;
  logic [31:0] adr, wdat, rdat;
  logic [3:0]  sel;
  logic [14:0] pc;
  int          num_errors = 0;
  int          checks = 0;
  int          ticks = 0;
  int          seed = 32'h8d16_5e9d;
  logic [32:0] exp_q[$];    // Expected {err, data} of each read
  logic [32:0] mask_q[$];   // Bits that matter in each read
  logic [7:0]  m_fm[128];   // Model of the file registers
  logic [7:0]  m_acc;
  logic        m_z;
  logic [6:0]  m_pch;
  logic [14:0] m_pc;

  initial forever #5 clk_i = ~clk_i;

  wb_host i_host (.clk_i(clk_i), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr),
    .sel_o(sel), .dat_o(wdat), .ack_i(ack), .err_i(err));
  skip_branch_or_inc_exec i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
    .err_o(err), .pc_o(pc), .busy_o(busy));

  task automatic stop_test();
    $display("errors %0d, checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input logic [32:0] got, exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] ad(input logic [11:0] o);
    return {20'h0, o};
  endfunction

  // Random idle gap makes the host prompt or slow
  task automatic wr(input logic [31:0] a, d);
    i_host.xfer(1'b1, a, d, int'($random(seed) & 1));
  endtask

  task automatic rd(input logic [31:0] a, input logic [32:0] e, m);
    exp_q.push_back(e & m);
    mask_q.push_back(m);
    i_host.xfer(1'b0, a, 32'h0, int'($random(seed) & 1));
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    while (busy === 1'b1 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    check({32'h0, busy}, 33'h0);
  endtask

  // Read answers are matched against the oldest note
  always @(posedge clk_i) begin : mon
    logic [32:0] m;
    if (!rst_i && (ack || err) && !we && mask_q.size() > 0) begin
      m = mask_q.pop_front();
      check({err, rdat} & m, exp_q.pop_front());
    end
  end

  // Hang guard, far above the few thousand cycles needed
  always @(posedge clk_i) begin
    ticks++;
    if (ticks == 20000) begin
      num_errors++;
      stop_test();
    end
  end

  initial begin
    logic [11:0] ofs[5];
    logic [13:0] ins;
    logic [6:0]  f;
    logic [7:0]  k, r;
    logic [10:0] j;
    logic        d, skip;
    int          op;
    ofs = '{`OFS_ACC, `OFS_STATUS, `OFS_PCH, `OFS_PC, `OFS_CYCLES};
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    foreach (ofs[i]) rd(ad(ofs[i]), 33'h0, '1);
    rd(32'h0000_1000, 33'h1_0000_0000, '1);
    wr(32'h0000_1000, 32'h0000_00FF);
    for (int i = 0; i < 90; i++) begin
      op = i % 6;
      {f, d, k, j} = 27'($random(seed));
      {m_fm[f], m_acc, m_pch, m_z} = 24'($random(seed));
      m_pc = 15'($random(seed));
      // Half the passes force a zero result
      if (i % 12 < 6) begin
        m_fm[f] = (op == 0) ? 8'h01 : (op == 3) ? 8'h00 : 8'hFF;
        if (op >= 3) m_acc = 8'h00;
        k = 8'h00;
      end
      wr(ad(`OFS_FILE_BASE) + {23'h0, f, 2'b00}, {24'h0, m_fm[f]});
      wr(ad(`OFS_ACC), {24'h0, m_acc});
      wr(ad(`OFS_PCH), {25'h0, m_pch});
      wr(ad(`OFS_PC), {17'h0, m_pc});
      wr(ad(`OFS_STATUS), {31'h0, m_z});
      wr(ad(`OFS_CYCLES), 32'h0);
      skip = 1'b0;
      r = 8'h00;
      case (op)
        0: begin
          r = m_fm[f] - 8'h01;
          skip = r == 8'h00;
          ins = {`OPC_DEC_SKIP, d, f};
        end
        1: begin
          r = m_fm[f] + 8'h01;
          skip = r == 8'h00;
          ins = {`OPC_INC_SKIP, d, f};
        end
        2: begin
          r = m_fm[f] + 8'h01;
          m_z = r == 8'h00;
          ins = {`OPC_INC, d, f};
        end
        3: begin
          r = m_acc | m_fm[f];
          m_z = r == 8'h00;
          ins = {`OPC_OR_REG, d, f};
        end
        4: begin
          r = m_acc | k;
          m_z = r == 8'h00;
          d = 1'b0;
          ins = {`OPC_OR_LIT, k};
        end
        default: ins = {`JTAG_JUMP, j};
      endcase
      if (op < 5 && d) m_fm[f] = r;
      else if (op < 5) m_acc = r;
      m_pc = (op == 5) ? {m_pch[6:3], j} : m_pc + (skip ? 15'h2 : 15'h1);
      wr(ad(`OFS_INSTR), {18'h0, ins});
      wait_idle();
      rd(ad(`OFS_ACC), {25'h0, m_acc}, '1);
      rd(ad(`OFS_FILE_BASE) + {23'h0, f, 2'b00}, {25'h0, m_fm[f]}, '1);
      // Zero flag, plus the taken-skip bit; busy and unknown must read low
      rd(ad(`OFS_STATUS), {30'h0, skip, 1'b0, m_z}, 33'hF);
      rd(ad(`OFS_PC), {18'h0, m_pc}, '1);
      rd(ad(`OFS_CYCLES), (skip || op == 5) ? 33'h2 : 33'h1, '1);
    end
    // Unrecognised word runs as a one-cycle no-operation and is flagged
    wr(ad(`OFS_CYCLES), 32'h0);
    wr(ad(`OFS_INSTR), 32'h0);
    wait_idle();
    rd(ad(`OFS_STATUS), {29'h0, 4'h8 | {3'h0, m_z}}, 33'hF);
    rd(ad(`OFS_PC), {18'h0, m_pc + 15'h1}, '1);
    rd(ad(`OFS_CYCLES), 33'h1, '1);
    stop_test();
  end
endmodule

`default_nettype wire
